// ==== rtl/tlbfc_pkg.sv ====
/*
 * shared constants and carrier types of the translation load and fault capture block.
 * assumes a 32-bit core with a 4-way, 32-set translation buffer held in flip-flops.
 */
`default_nettype none
package tlbfc_pkg;
	localparam int NUM_WAYS = 4;
	localparam int NUM_SETS = 32;
	// register offsets on the bus
	localparam logic [7:0] OFS_EH  = 8'h00;
	localparam logic [7:0] OFS_EL  = 8'h04;
	localparam logic [7:0] OFS_CTL = 8'h08;
	localparam logic [7:0] OFS_TEA = 8'h0c;
	localparam logic [7:0] OFS_EVT = 8'h10;
	localparam logic [7:0] OFS_SPC = 8'h14;
	localparam logic [7:0] OFS_SSR = 8'h18;
	localparam logic [7:0] OFS_SR  = 8'h1c;
	localparam logic [7:0] OFS_VBR = 8'h20;
	// field positions
	localparam int EH_VPN_LSB  = 10;
	localparam int EH_ADDRESS_SPACE_ID_LSB = 0;
	localparam int EL_PPN_LSB  = 10;
	localparam int EL_V_BIT    = 8;
	localparam int EL_PR_LSB   = 5;
	localparam int EL_SZ_BIT   = 4;
	localparam int EL_C_BIT    = 3;
	localparam int EL_D_BIT    = 2;
	localparam int EL_SH_BIT   = 1;
	localparam int CTL_IX_BIT  = 9;
	localparam int CTL_RC_LSB  = 26;
	localparam int SR_MD_BIT   = 30;
	localparam int SR_RB_BIT   = 29;
	localparam int SR_BL_BIT   = 28;
	// writable bits and reset values
	localparam logic [31:0] EH_MASK = 32'hfffffcff;
	localparam logic [31:0] EL_MASK = 32'hfffffd7e;
	localparam logic [31:0] SR_RST  = 32'h70000000;
	localparam logic [31:0] REG_RST = 32'h00000000;
	// event codes and vector offsets
	localparam logic [31:0] EVT_MISS_LD  = 32'h00000040;
	localparam logic [31:0] EVT_MISS_ST  = 32'h00000060;
	localparam logic [31:0] EVT_FIRST_WR = 32'h00000080;
	localparam logic [31:0] EVT_PROT_LD  = 32'h000000a0;
	localparam logic [31:0] EVT_PROT_ST  = 32'h000000c0;
	localparam logic [31:0] VEC_MISS     = 32'h00000400;
	localparam logic [31:0] VEC_GENERAL  = 32'h00000100;

	typedef enum logic [2:0] {FK_NONE, FK_MISS, FK_PROT, FK_INVALID, FK_FIRST_WRITE} tlbfc_fault_type;

	typedef struct packed {
		logic [21:0] virtual_page_number;
		logic [7:0]  address_space_id;
		logic [21:0] physical_page_number;
		logic        v;
		logic        sz;
		logic [1:0]  pr;
		logic        c;
		logic        d;
		logic        sh;
	} tlbfc_entry_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] va;
		logic        write;
		logic [31:0] pc;
		logic        delay_slot;
		logic [31:0] branch_pc;
	} tlbfc_req_type;

	typedef struct packed {
		logic            hit;
		logic [31:0]     pa;
		logic            fault;
		tlbfc_fault_type kind;
		logic [31:0]     redirect_pc;
	} tlbfc_rsp_type;
endpackage : tlbfc_pkg
`default_nettype wire

// ==== rtl/tlbfc_lookup.sv ====
/*
 * compares one indexed set against a request and classifies the outcome.
 * assumes the caller has already selected the set; purely combinational.
 */
`timescale 1ns/10ps
`default_nettype none
module tlbfc_lookup
	import tlbfc_pkg::*;
(
	// indexed set and request
	input  wire tlbfc_entry_type [NUM_WAYS-1:0] ways,
	input  wire logic [31:0]     va,
	input  wire logic [7:0]      address_space_id,
	input  wire logic            priv,
	input  wire logic            wr,
	// outcome
	output tlbfc_fault_type      kind,
	output logic [1:0]           way,
	output logic [1:0]           free_way,
	output logic                 all_valid,
	output logic [31:0]          pa
);
	logic [NUM_WAYS-1:0] match;
	logic [NUM_WAYS-1:0] hit;
	logic                ok;
	tlbfc_entry_type     e;

	genvar w;
	for (w = 0; w < NUM_WAYS; w++) begin : g_way
		assign match[w] = ways[w].virtual_page_number[21:2] == va[31:12]
			&& (ways[w].sz || ways[w].virtual_page_number[1:0] == va[11:10])
			&& (ways[w].sh || ways[w].address_space_id == address_space_id);
		assign hit[w] = match[w] && ways[w].v;
	end

	always_comb begin
		way = 2'h0;
		free_way = 2'h0;
		for (int i = NUM_WAYS - 1; i >= 0; i--) begin
			if (match[i]) way = 2'(i);
			if (!ways[i].v) free_way = 2'(i);
		end
		for (int i = NUM_WAYS - 1; i >= 0; i--) begin
			if (hit[i]) way = 2'(i);
		end
		all_valid = &{ways[3].v, ways[2].v, ways[1].v, ways[0].v};
		e = ways[way];
		ok = priv ? (!wr || e.pr[0]) : (e.pr[1] && (!wr || e.pr[0]));
		if (match == '0) kind = FK_MISS;
		else if (!e.v) kind = FK_INVALID;
		else if (!ok) kind = FK_PROT;
		else if (wr && !e.d) kind = FK_FIRST_WRITE;
		else kind = FK_NONE;
		pa = e.sz ? {e.physical_page_number[21:2], va[11:0]} : {e.physical_page_number, va[9:0]};
	end
endmodule : tlbfc_lookup
`default_nettype wire

// ==== rtl/tlbfc_cache_map.sv ====
/*
 * cache index and tag split for a translated access.
 * assumes the cache supplies the stored tag of the line at the index given.
 */
`timescale 1ns/10ps
`default_nettype none
module tlbfc_cache_map (
	// addresses
	input  wire logic [31:0] va,
	input  wire logic [31:0] pa,
	input  wire logic [21:0] line_tag,
	// results
	output logic [6:0]       index,
	output logic             tag_hit
);
	// virtual index keeps lookup in parallel with translation
	assign index   = va[10:4];
	assign tag_hit = line_tag == pa[31:10];
endmodule : tlbfc_cache_map
`default_nettype wire

// ==== rtl/tlbfc_top.sv ====
/*
 * translation buffer storage, load operation, fault capture and core redirect.
 * assumes a same-clock core that issues one request per cycle and a classic wishbone master.
 */
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tlbfc_top
	import tlbfc_pkg::*;
(
	// clock and reset
	input  wire logic          CLK_SYS,
	input  wire logic          RST_N,
	// register bus
	input  wire logic          WB_CYC_I,
	input  wire logic          WB_STB_I,
	input  wire logic          WB_WE_I,
	input  wire logic [7:0]    WB_ADR_I,
	input  wire logic [3:0]    WB_SEL_I,
	input  wire logic [31:0]   WB_DAT_I,
	output logic [31:0]        WB_DAT_O,
	output logic               WB_ACK_O,
	// core side
	input  wire tlbfc_req_type CORE_REQ,
	input  wire logic          LOAD_TLB,
	output tlbfc_rsp_type      CORE_RSP,
	output logic [31:0]        STATUS_REG,
	// cache side
	input  wire logic [21:0]   CACHE_LINE_TAG,
	output logic [6:0]         CACHE_INDEX,
	output logic               CACHE_TAG_HIT
);
	logic [31:0]     eh_q, eh_d, el_q, el_d;
	logic [31:0]     tea_q, tea_d, evt_q, evt_d;
	logic [31:0]     spc_q, spc_d, ssr_q, ssr_d;
	logic [31:0]     sr_q, sr_d, vbr_q, vbr_d;
	logic            ix_q, ix_d;
	logic [1:0]      rc_q, rc_d;
	logic            ack_q, ack_d;
	logic [31:0]     dat_q, dat_d;
	logic            bus_req;
	tlbfc_rsp_type   rsp_q, rsp_d;
	logic [6:0]      cidx_q, cidx_d;
	logic            chit_q, chit_d;
	tlbfc_entry_type [NUM_WAYS-1:0] tlb_q [NUM_SETS];
	tlbfc_entry_type [NUM_WAYS-1:0] tlb_d [NUM_SETS];
	tlbfc_entry_type ld_entry;
	logic [4:0]      req_set, ld_set;
	tlbfc_fault_type lk_kind;
	logic [1:0]      lk_way, lk_free;
	logic            lk_full;
	logic [31:0]     lk_pa;
	logic [6:0]      c_idx;
	logic            c_hit;
	logic            flt;

	function automatic logic [4:0] set_of(input logic [31:0] a, input logic [7:0] address_space_id, input logic ix);
		return a[16:12] ^ (ix ? address_space_id[4:0] : 5'h00);
	endfunction : set_of

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : merge

	assign req_set = set_of(CORE_REQ.va, eh_q[EH_ADDRESS_SPACE_ID_LSB +: 8], ix_q);
	assign ld_set  = set_of(eh_q, eh_q[EH_ADDRESS_SPACE_ID_LSB +: 8], ix_q);

	tlbfc_lookup u_lookup (
		.ways      (tlb_q[req_set]),
		.va        (CORE_REQ.va),
		.address_space_id      (eh_q[EH_ADDRESS_SPACE_ID_LSB +: 8]),
		.priv      (sr_q[SR_MD_BIT]),
		.wr        (CORE_REQ.write),
		.kind      (lk_kind),
		.way       (lk_way),
		.free_way  (lk_free),
		.all_valid (lk_full),
		.pa        (lk_pa)
	);

	tlbfc_cache_map u_cache_map (
		.va       (CORE_REQ.va),
		.pa       (lk_pa),
		.line_tag (CACHE_LINE_TAG),
		.index    (c_idx),
		.tag_hit  (c_hit)
	);

	assign flt = CORE_REQ.valid && lk_kind != FK_NONE;

	// registers: bus access first, fault capture last so hardware wins a same-cycle write
	always_comb begin
		eh_d  = eh_q;
		el_d  = el_q;
		tea_d = tea_q;
		evt_d = evt_q;
		spc_d = spc_q;
		ssr_d = ssr_q;
		sr_d  = sr_q;
		vbr_d = vbr_q;
		ix_d  = ix_q;
		rc_d  = rc_q;
		bus_req = WB_CYC_I && WB_STB_I && !ack_q;
		ack_d = bus_req;
		dat_d = '0;
		if (bus_req && !WB_WE_I) begin
			case (WB_ADR_I)
				OFS_EH:  dat_d = eh_q;
				OFS_EL:  dat_d = el_q;
				OFS_CTL: begin
					dat_d[CTL_IX_BIT] = ix_q;
					dat_d[CTL_RC_LSB +: 2] = rc_q;
				end
				OFS_TEA: dat_d = tea_q;
				OFS_EVT: dat_d = evt_q;
				OFS_SPC: dat_d = spc_q;
				OFS_SSR: dat_d = ssr_q;
				OFS_SR:  dat_d = sr_q;
				OFS_VBR: dat_d = vbr_q;
				default: dat_d = '0;
			endcase
		end
		if (bus_req && WB_WE_I) begin
			case (WB_ADR_I)
				OFS_EH:  eh_d = merge(eh_q, WB_DAT_I, WB_SEL_I) & EH_MASK;
				OFS_EL:  el_d = merge(el_q, WB_DAT_I, WB_SEL_I) & EL_MASK;
				OFS_CTL: begin
					if (WB_SEL_I[CTL_IX_BIT / 8]) ix_d = WB_DAT_I[CTL_IX_BIT];
					if (WB_SEL_I[CTL_RC_LSB / 8]) rc_d = WB_DAT_I[CTL_RC_LSB +: 2];
				end
				OFS_TEA: tea_d = merge(tea_q, WB_DAT_I, WB_SEL_I);
				OFS_EVT: evt_d = merge(evt_q, WB_DAT_I, WB_SEL_I);
				OFS_SPC: spc_d = merge(spc_q, WB_DAT_I, WB_SEL_I);
				OFS_SSR: ssr_d = merge(ssr_q, WB_DAT_I, WB_SEL_I);
				OFS_SR:  sr_d  = merge(sr_q, WB_DAT_I, WB_SEL_I);
				OFS_VBR: vbr_d = merge(vbr_q, WB_DAT_I, WB_SEL_I);
				default: ;
			endcase
		end
		if (flt) begin
			eh_d[31:EH_VPN_LSB] = CORE_REQ.va[31:EH_VPN_LSB];
			tea_d = CORE_REQ.va;
			spc_d = CORE_REQ.delay_slot ? CORE_REQ.branch_pc : CORE_REQ.pc;
			ssr_d = sr_q;
			sr_d = sr_q;
			sr_d[SR_MD_BIT] = 1'b1;
			sr_d[SR_BL_BIT] = 1'b1;
			sr_d[SR_RB_BIT] = 1'b1;
			unique case (lk_kind)
				FK_MISS: begin
					evt_d = CORE_REQ.write ? EVT_MISS_ST : EVT_MISS_LD;
					rc_d = lk_full ? rc_q + 2'h1 : lk_free;
				end
				FK_PROT: begin
					evt_d = CORE_REQ.write ? EVT_PROT_ST : EVT_PROT_LD;
					rc_d = lk_way;
				end
				FK_INVALID: begin
					evt_d = CORE_REQ.write ? EVT_MISS_ST : EVT_MISS_LD;
					rc_d = lk_way;
				end
				FK_FIRST_WRITE: begin
					evt_d = EVT_FIRST_WR;
					rc_d = lk_way;
				end
				FK_NONE: ;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			eh_q  <= REG_RST;
			el_q  <= REG_RST;
			tea_q <= REG_RST;
			evt_q <= REG_RST;
			spc_q <= REG_RST;
			ssr_q <= REG_RST;
			sr_q  <= SR_RST;
			vbr_q <= REG_RST;
			ix_q  <= 1'b0;
			rc_q  <= 2'h0;
			ack_q <= 1'b0;
			dat_q <= REG_RST;
		end else begin
			eh_q  <= eh_d;
			el_q  <= el_d;
			tea_q <= tea_d;
			evt_q <= evt_d;
			spc_q <= spc_d;
			ssr_q <= ssr_d;
			sr_q  <= sr_d;
			vbr_q <= vbr_d;
			ix_q  <= ix_d;
			rc_q  <= rc_d;
			ack_q <= ack_d;
			dat_q <= dat_d;
		end
	end

	// load operation writes the selected set and way from the two entry registers
	always_comb begin
		ld_entry.virtual_page_number  = eh_q[EH_VPN_LSB +: 22];
		ld_entry.address_space_id = eh_q[EH_ADDRESS_SPACE_ID_LSB +: 8];
		ld_entry.physical_page_number  = el_q[EL_PPN_LSB +: 22];
		ld_entry.v    = el_q[EL_V_BIT];
		ld_entry.sz   = el_q[EL_SZ_BIT];
		ld_entry.pr   = el_q[EL_PR_LSB +: 2];
		ld_entry.c    = el_q[EL_C_BIT];
		ld_entry.d    = el_q[EL_D_BIT];
		ld_entry.sh   = el_q[EL_SH_BIT];
		tlb_d = tlb_q;
		if (LOAD_TLB) tlb_d[ld_set][rc_q] = ld_entry;
	end

	// whole array clears so no stale entry can hit after reset
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int s = 0; s < NUM_SETS; s++) tlb_q[s] <= '0;
		end else begin
			tlb_q <= tlb_d;
		end
	end

	// core answer, one cycle after the request
	always_comb begin
		rsp_d = '0;
		rsp_d.kind = lk_kind;
		rsp_d.pa = lk_pa;
		rsp_d.hit = CORE_REQ.valid && lk_kind == FK_NONE;
		rsp_d.fault = flt;
		if (!CORE_REQ.valid) rsp_d.kind = FK_NONE;
		if (flt) rsp_d.redirect_pc = vbr_q + ((lk_kind == FK_MISS) ? VEC_MISS : VEC_GENERAL);
		cidx_d = c_idx;
		chit_d = CORE_REQ.valid && lk_kind == FK_NONE && c_hit;
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			rsp_q  <= '0;
			cidx_q <= 7'h00;
			chit_q <= 1'b0;
		end else begin
			rsp_q  <= rsp_d;
			cidx_q <= cidx_d;
			chit_q <= chit_d;
		end
	end

	assign WB_DAT_O      = dat_q;
	assign WB_ACK_O      = ack_q;
	assign CORE_RSP      = rsp_q;
	assign STATUS_REG    = sr_q;
	assign CACHE_INDEX   = cidx_q;
	assign CACHE_TAG_HIT = chit_q;

	AST_MISS_VECTOR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_MISS |=> CORE_RSP.fault && CORE_RSP.redirect_pc == $past(vbr_q) + 32'h00000400)
		else $error("miss did not vector to base plus 400");

	AST_PROT_VECTOR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_PROT |=> CORE_RSP.redirect_pc == $past(vbr_q) + 32'h00000100)
		else $error("protection fault did not vector to base plus 100");

	AST_MISS_CODE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_MISS |=> evt_q == ($past(CORE_REQ.write) ? 32'h60 : 32'h40))
		else $error("wrong miss event code");

	AST_PROT_CODE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_PROT |=> evt_q == ($past(CORE_REQ.write) ? 32'hc0 : 32'ha0))
		else $error("wrong protection event code");

	AST_STATUS_SAVE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		flt |=> ssr_q == $past(sr_q) && sr_q[SR_MD_BIT] && sr_q[SR_BL_BIT] && sr_q[SR_RB_BIT])
		else $error("status not saved or mode bits not set");

	AST_SAVED_PC: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		flt && CORE_REQ.delay_slot |=> spc_q == $past(CORE_REQ.branch_pc))
		else $error("delay slot fault did not save branch address");

	AST_FAULT_ADDR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		flt |=> tea_q == $past(CORE_REQ.va) && eh_q[31:10] == $past(CORE_REQ.va[31:10]))
		else $error("fault address or page not captured");

	AST_PROT_WAY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_PROT |=> rc_q == $past(lk_way))
		else $error("protection fault way not recorded");

	AST_MISS_WAY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_MISS && lk_full |=> rc_q == 2'($past(rc_q) + 2'h1))
		else $error("way counter did not advance on full set");

	AST_LOAD_WRITE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		LOAD_TLB ##1 !LOAD_TLB |-> tlb_q[$past(ld_set)][$past(rc_q)] == $past(ld_entry))
		else $error("load did not write the selected way");

	AST_BUS_ACK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
		else $error("bus acknowledge not a single cycle after one wait");

	AST_MISS_FREE_WAY: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid && lk_kind == FK_MISS && !lk_full |=> rc_q == $past(lk_free))
		else $error("miss did not take the lowest free way");

	AST_PLAIN_PC: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		flt && !CORE_REQ.delay_slot |=> spc_q == $past(CORE_REQ.pc))
		else $error("fault did not save the faulting instruction address");

	AST_CACHE_INDEX: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_REQ.valid |=> CACHE_INDEX == $past(CORE_REQ.va[10:4]))
		else $error("cache index not taken from virtual bits 10 to 4");

	AST_FAULT_KIND: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CORE_RSP.fault |-> CORE_RSP.kind != FK_NONE && !CORE_RSP.hit)
		else $error("fault reported without a kind or together with a hit");
endmodule : tlbfc_top
`default_nettype wire

// ==== tb/tlbfc_core_model.sv ====
/*
 * behavioural core pipeline: issues translated accesses and load operations.
 * assumes the same clock as the block; every signal changes just after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module tlbfc_core_model
	import tlbfc_pkg::*;
(
	// clock
	input  wire logic           clk,
	// block side
	output var tlbfc_req_type   req,
	output var logic            load_tlb,
	output var logic [21:0]     line_tag,
	input  wire tlbfc_rsp_type  rsp
);
	initial begin
		req = '0;
		load_tlb = 1'b0;
		line_tag = 22'h000000;
	end

	// one access; the response stands one cycle after the taking edge
	task automatic access(input logic [31:0] va, input logic wr, input logic [31:0] pc, input logic ds,
		input logic [21:0] tag, output tlbfc_rsp_type r);
		@(posedge clk);
		req <= '{valid: 1'b1, va: va, write: wr, pc: pc, delay_slot: ds, branch_pc: pc - 32'h2};
		line_tag <= tag;
		@(posedge clk);
		// idle lines carry inverted values so stale data is never mistaken for live data
		req <= '{valid: 1'b0, va: ~va, write: ~wr, pc: ~pc, delay_slot: ~ds, branch_pc: ~pc};
		line_tag <= ~tag;
		@(posedge clk);
		r = rsp;
	endtask : access

	// load pulse, followed by a spare cycle before any translated access
	task automatic load_op();
		@(posedge clk);
		load_tlb <= 1'b1;
		@(posedge clk);
		load_tlb <= 1'b0;
		@(posedge clk);
	endtask : load_op
endmodule : tlbfc_core_model
`default_nettype wire

// ==== tb/tlbfc_top_tb.sv ====
/*
 * self-checking bench: wishbone register access, fault capture, load and lookup scenarios.
 * assumes the core model drives the core side and the bench acts as the bus master.
 */
`timescale 1ns/10ps
`default_nettype none
module tlbfc_top_tb
	import tlbfc_pkg::*;
;
	logic          clk_sys;
	logic          rst_n;
	logic          cyc;
	logic          stb;
	logic          we_i;
	logic [7:0]    adr_i;
	logic [31:0]   dat_i;
	logic [31:0]   dat_o;
	logic          ack;
	tlbfc_req_type req;
	logic          load_tlb;
	tlbfc_rsp_type rsp;
	logic [31:0]   status;
	logic [21:0]   line_tag;
	logic [6:0]    cache_index;
	logic          cache_tag_hit;
	int            errors;
	int            comparisons;
	int            cycles;
	tlbfc_rsp_type r;

	tlbfc_top u_tlbfc_top (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we_i),
		.WB_ADR_I(adr_i), .WB_SEL_I(4'hf), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
		.CORE_REQ(req), .LOAD_TLB(load_tlb), .CORE_RSP(rsp), .STATUS_REG(status),
		.CACHE_LINE_TAG(line_tag), .CACHE_INDEX(cache_index), .CACHE_TAG_HIT(cache_tag_hit));

	tlbfc_core_model u_tlbfc_core_model (.clk(clk_sys), .req(req), .load_tlb(load_tlb),
		.line_tag(line_tag), .rsp(rsp));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	// the ceiling is far above the fewer than two hundred cycles the scenarios need
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors = errors + 1;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
		output logic [31:0] rdat);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we_i <= we;
		adr_i <= adr;
		dat_i <= wdat;
		do @(posedge clk_sys); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		dat_i <= ~wdat;
	endtask : wb_cycle

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] d;
		wb_cycle(1'b1, adr, dat, d);
	endtask : wr

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] d;
		wb_cycle(1'b0, adr, 32'h00000000, d);
		chk(d, exp);
	endtask : rd_chk

	task automatic t_reset();
		rd_chk(OFS_SR, SR_RST);
		rd_chk(OFS_CTL, 32'h00000000);
		rd_chk(8'h40, 32'h00000000);
	endtask : t_reset

	// empty buffer: a load access misses and every capture register is loaded
	task automatic t_miss();
		wr(OFS_VBR, 32'h80000000);
		wr(OFS_SR, 32'h00000000);
		u_tlbfc_core_model.access(32'h00013456, 1'b0, 32'h00001000, 1'b0, 22'h000000, r);
		chk({31'h0, r.fault}, 32'h1);
		chk(32'(r.kind), 32'(FK_MISS));
		chk(r.redirect_pc, 32'h80000400);
		chk(status, 32'h70000000);
		rd_chk(OFS_EH, 32'h00013400);
		rd_chk(OFS_TEA, 32'h00013456);
		rd_chk(OFS_EVT, EVT_MISS_LD);
		rd_chk(OFS_SPC, 32'h00001000);
		rd_chk(OFS_SSR, 32'h00000000);
		rd_chk(OFS_SR, 32'h70000000);
		rd_chk(OFS_CTL, 32'h00000000);
		u_tlbfc_core_model.access(32'h00013456, 1'b1, 32'h00001004, 1'b0, 22'h000000, r);
		rd_chk(OFS_EVT, EVT_MISS_ST);
	endtask : t_miss

	// only the low half is written; the captured page and way complete the entry
	task automatic t_load();
		logic [31:0] pa;
		pa = 32'h0abcd456;
		wr(OFS_EL, 32'h0abcd174);
		u_tlbfc_core_model.load_op();
		u_tlbfc_core_model.access(32'h00013456, 1'b1, 32'h00001008, 1'b0, pa[31:10], r);
		chk({31'h0, r.hit}, 32'h1);
		chk(r.pa, pa);
		chk({25'h0, cache_index}, 32'h00000045);
		chk({31'h0, cache_tag_hit}, 32'h1);
	endtask : t_load

	// set 19 fills way by way; a full set advances the way field and wraps
	task automatic t_way();
		u_tlbfc_core_model.access(32'h00053456, 1'b0, 32'h00001010, 1'b0, 22'h000000, r);
		chk(32'(r.kind), 32'(FK_MISS));
		rd_chk(OFS_CTL, 32'h04000000);
		u_tlbfc_core_model.load_op();
		wr(OFS_CTL, 32'h08000000);
		u_tlbfc_core_model.load_op();
		wr(OFS_CTL, 32'h0c000000);
		u_tlbfc_core_model.load_op();
		u_tlbfc_core_model.access(32'h00073456, 1'b0, 32'h00001014, 1'b0, 22'h000000, r);
		rd_chk(OFS_CTL, 32'h00000000);
		wr(OFS_CTL, 32'h04000000);
		u_tlbfc_core_model.access(32'h00093456, 1'b0, 32'h00001018, 1'b0, 22'h000000, r);
		rd_chk(OFS_CTL, 32'h08000000);
	endtask : t_way

	// software picked way 2; a privileged store to a read-only page in a delay slot
	task automatic t_prot();
		wr(OFS_CTL, 32'h08000000);
		wr(OFS_EH, 32'h00025000);
		wr(OFS_EL, 32'h01234114);
		u_tlbfc_core_model.load_op();
		u_tlbfc_core_model.access(32'h00025010, 1'b0, 32'h00002010, 1'b0, 22'h000000, r);
		chk({31'h0, r.hit}, 32'h1);
		wr(OFS_CTL, 32'h04000000);
		u_tlbfc_core_model.access(32'h00025020, 1'b1, 32'h00002002, 1'b1, 22'h000000, r);
		chk(32'(r.kind), 32'(FK_PROT));
		chk(r.redirect_pc, 32'h80000100);
		rd_chk(OFS_EVT, EVT_PROT_ST);
		rd_chk(OFS_SPC, 32'h00002000);
		rd_chk(OFS_TEA, 32'h00025020);
		rd_chk(OFS_CTL, 32'h08000000);
		wr(OFS_SR, 32'h00000000);
		u_tlbfc_core_model.access(32'h00025030, 1'b0, 32'h00002010, 1'b0, 22'h000000, r);
		chk(32'(r.kind), 32'(FK_PROT));
		rd_chk(OFS_EVT, EVT_PROT_LD);
	endtask : t_prot

	// hashed set 4 xor 3 holds the entry; the plain set 4 does not
	task automatic t_hash();
		wr(OFS_CTL, 32'h00000200);
		wr(OFS_EH, 32'h00044003);
		wr(OFS_EL, 32'h00040174);
		u_tlbfc_core_model.load_op();
		u_tlbfc_core_model.access(32'h00044010, 1'b0, 32'h00003000, 1'b0, 22'h000000, r);
		chk({31'h0, r.hit}, 32'h1);
		wr(OFS_CTL, 32'h00000000);
		u_tlbfc_core_model.access(32'h00044010, 1'b0, 32'h00003004, 1'b0, 22'h000000, r);
		chk(32'(r.kind), 32'(FK_MISS));
	endtask : t_hash

	initial begin
		errors = 0;
		comparisons = 0;
		cycles = 0;
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		dat_i = 32'h00000000;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_miss();
		t_load();
		t_way();
		t_prot();
		t_hash();
		print_verdict();
	end
endmodule : tlbfc_top_tb
`default_nettype wire
